// >>> hdl/dummy_never_used_placeholder_none.sv
// intentionally empty compile unit
`timescale 1ns/100ps

// >>> hdl/serial_port_slot_mapper_isoc.sv
// audio serial port channel slot mapper with isochronous null handling
`timescale 1ns/100ps
// Behaviour
// R1: each channel start position is set in single bit-clock steps
// R2: offset zero places the channel on the first bit of a frame
// R3: channel width is 8, 16, 24 or 32 bits
// R4: converter paths carry 24 bits; a 32-bit word loses its low byte
// R5: only the S/PDIF feed keeps the full 32-bit word
// R6: host keeps every channel inside the programmed frame length
// R7: host maps no bit twice, except receive channels sharing bits
// R8: isochronous mode carries streams slower than the frame rate
// R9: host never mixes isochronous and native streams on the port
// R10: S/PDIF feed takes native-rate streams only
// R11: a select bit per direction picks code or indicator-byte nulls
// R12: code mode inserts full-scale nulls; genuine ones bumped by one
// R13: indicator mode appends a byte; inserted nulls are full-scale words
// R14: indicator bit one means valid, zero means null; position selectable
// R15: code mode removal drops every negative full-scale sample
// R16: indicator mode removal drops nulls and strips the trailing byte
// R17: rate fields act only in isochronous mode: 48k, 96k, 192k
// R18: rates only pace insertion and feed converters; no effect elsewhere
// R19: host spaces valid samples within one period of an ideal clock
// R20: error accumulator from zero chooses sample or null each frame
// R21: 48 kHz frame gives the fixed valid/null patterns per stream rate
// R22: long-term valid sample rate equals the stream rate
// R23: frame length is 16 to 4096 bit clocks and bounds slots
// R24: equal-half mode counts offsets within the active half
// R25: bits go out most significant first from the offset for the width
module serial_port_slot_mapper_isoc (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        bit_clk,
    input  wire logic        frame_sync,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe,
    input  wire logic [12:0] frame_length_low,
    input  wire logic        equal_half_frame_mode,
    input  wire logic [3:0]  tx_chan1_offset_high,
    input  wire logic [7:0]  tx_chan1_offset_low,
    input  wire logic [1:0]  tx_chan1_width,
    input  wire logic        tx_chan1_phase,
    input  wire logic [3:0]  tx_chan2_offset_high,
    input  wire logic [7:0]  tx_chan2_offset_low,
    input  wire logic [1:0]  tx_chan2_width,
    input  wire logic        tx_chan2_phase,
    input  wire logic [3:0]  rx_group0_chan1_offset_high,
    input  wire logic [7:0]  rx_group0_chan1_offset_low,
    input  wire logic [1:0]  rx_group0_chan1_width,
    input  wire logic        rx_group0_chan1_phase,
    input  wire logic [3:0]  rx_group1_chan1_offset_high,
    input  wire logic [7:0]  rx_group1_chan1_offset_low,
    input  wire logic [1:0]  rx_group1_chan1_width,
    input  wire logic        rx_group1_chan1_phase,
    input  wire logic        tx_isoc_enable,
    input  wire logic        rx_isoc_enable,
    input  wire logic        tx_null_scheme_select,
    input  wire logic        rx_null_scheme_select,
    input  wire logic [2:0]  tx_null_flag_position,
    input  wire logic [2:0]  rx_null_flag_position,
    input  wire logic [1:0]  tx_isoc_rate,
    input  wire logic [1:0]  rx_isoc_rate,
    input  wire logic [2:0]  tx_stream_rate,
    input  wire logic [23:0] tx_chan1_sample,
    input  wire logic [23:0] tx_chan2_sample,
    output logic             tx_sample_take,
    output logic [23:0]      rx_group0_chan1_sample,
    output logic             rx_group0_chan1_valid,
    output logic [23:0]      rx_group1_chan1_sample,
    output logic             rx_group1_chan1_valid,
    output logic [31:0]      spdif_word,
    output logic             spdif_valid,
    output logic [1:0]       tx_conv_rate,
    output logic [1:0]       rx_conv_rate
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       bclk_s;
        logic [2:0]       fs_s;
        logic [2:0]       din_s;
        logic             bclk_st;
        logic             fs_st;
        logic             din_st;
        logic             start_pend;
        logic             cap;
        logic             drv;
        logic             load;
        logic [12:0]      rx_idx;
        logic [12:0]      tx_pos;
        logic             rx_phase;
        logic             tx_phase;
        logic             tx_null;
        logic [1:0][31:0] tx_word;
        logic [1:0][31:0] rx_word;
        logic [8:0]       err;
        logic             sdout;
        logic             sdout_oe;
        logic             take;
        logic [1:0][23:0] rx_sample;
        logic [1:0]       rx_valid;
        logic [31:0]      spdif_word;
        logic             spdif_valid;
        logic [1:0]       tx_rate;
        logic [1:0]       rx_rate;
    } state_t;

    state_t           st_r;
    state_t           st_nxt;
    logic [12:0]      lim;
    logic [3:0][12:0] cfg_off;
    logic [3:0][1:0]  cfg_w;
    logic [3:0]       cfg_ap;
    logic [3:0]       in_slot;
    logic [3:0][4:0]  rel;
    logic [3:0]       last;
    logic [1:0]       rx_drop;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] width_bits(input logic [1:0] code);
        width_bits = {1'b0, code, 3'b000} + slot_map_pkg::BYTE_BITS;
    endfunction

    function automatic logic [31:0] top_mask(input logic [5:0] nbits);
        top_mask = ~(slot_map_pkg::ALL_ONES >> nbits);
    endfunction

    function automatic logic [8:0] frame_units(input logic [1:0] code);
        case (code)
            slot_map_pkg::RATE_96K:  frame_units = slot_map_pkg::UNITS_96K;
            slot_map_pkg::RATE_192K: frame_units = slot_map_pkg::UNITS_192K;
            default:                 frame_units = slot_map_pkg::UNITS_48K;
        endcase
    endfunction

    function automatic logic [8:0] stream_units(input logic [2:0] code);
        case (code)
            3'h0:    stream_units = slot_map_pkg::UNITS_8K;
            3'h1:    stream_units = slot_map_pkg::UNITS_12K;
            3'h2:    stream_units = slot_map_pkg::UNITS_16K;
            3'h3:    stream_units = slot_map_pkg::UNITS_24K;
            3'h4:    stream_units = slot_map_pkg::UNITS_32K;
            3'h6:    stream_units = slot_map_pkg::UNITS_96K;
            3'h7:    stream_units = slot_map_pkg::UNITS_192K;
            default: stream_units = slot_map_pkg::UNITS_48K;
        endcase
    endfunction

    // ------------------------------------------------------------
    // channel slot windows: 0,1 transmit, 2,3 receive
    // ------------------------------------------------------------
    assign lim     = equal_half_frame_mode ? {1'b0, frame_length_low[12:1]} : frame_length_low; // [R23] [R24]
    assign cfg_off = {{1'b0, rx_group1_chan1_offset_high, rx_group1_chan1_offset_low},
                      {1'b0, rx_group0_chan1_offset_high, rx_group0_chan1_offset_low},
                      {1'b0, tx_chan2_offset_high, tx_chan2_offset_low},
                      {1'b0, tx_chan1_offset_high, tx_chan1_offset_low}};
    assign cfg_w   = {rx_group1_chan1_width, rx_group0_chan1_width, tx_chan2_width, tx_chan1_width};
    assign cfg_ap  = {rx_group1_chan1_phase, rx_group0_chan1_phase, tx_chan2_phase, tx_chan1_phase};

    slot_if sl [4] ();

    for (genvar g = 0; g < 4; g++) begin : g_slot
        assign sl[g].offset       = cfg_off[g]; // [R1]
        assign sl[g].width_code   = cfg_w[g]; // [R3]
        assign sl[g].active_phase = cfg_ap[g];
        assign sl[g].half_mode    = equal_half_frame_mode;
        assign sl[g].limit        = lim;
        assign sl[g].pos          = (g < 2) ? st_r.tx_pos : st_r.rx_idx;
        assign sl[g].phase        = (g < 2) ? st_r.tx_phase : st_r.rx_phase;
        assign in_slot[g]         = sl[g].in_slot;
        assign rel[g]             = sl[g].rel;
        assign last[g]            = sl[g].last;
        slot_window u_win (
            .s (sl[g])
        );
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic        bclk_new;
        logic        fs_new;
        logic        rise;
        logic        fs_start;
        logic        wrap;
        logic        send;
        logic [8:0]  fu;
        logic [8:0]  su;
        logic [5:0]  wb;
        logic [31:0] w;
        logic [31:0] audio;
        logic [7:0]  fb;
        logic        isnull;
        bclk_new = st_r.bclk_st;
        fs_new   = st_r.fs_st;
        rise     = 1'b0;
        fs_start = 1'b0;
        wrap     = 1'b0;
        send     = 1'b1;
        fu       = frame_units(tx_isoc_rate);
        su       = stream_units(tx_stream_rate);
        wb       = '0;
        w        = '0;
        audio    = '0;
        fb       = '0;
        isnull   = 1'b0;
        rx_drop  = '0;
        st_nxt   = st_r;
        st_nxt.take        = 1'b0;
        st_nxt.rx_valid    = '0;
        st_nxt.spdif_valid = 1'b0;
        st_nxt.load        = 1'b0;
        // three-stage synchronisers; a change counts when stages two and three agree
        st_nxt.bclk_s = {st_r.bclk_s[1:0], bit_clk};
        st_nxt.fs_s   = {st_r.fs_s[1:0], frame_sync};
        st_nxt.din_s  = {st_r.din_s[1:0], serial_in};
        if (st_r.bclk_s[1] == st_r.bclk_s[2]) begin
            bclk_new = st_r.bclk_s[2];
        end
        if (st_r.fs_s[1] == st_r.fs_s[2]) begin
            fs_new = st_r.fs_s[2];
        end
        if (st_r.din_s[1] == st_r.din_s[2]) begin
            st_nxt.din_st = st_r.din_s[2];
        end
        st_nxt.bclk_st = bclk_new;
        st_nxt.fs_st   = fs_new;
        rise     = bclk_new & ~st_r.bclk_st;
        fs_start = equal_half_frame_mode ? (fs_new ^ st_r.fs_st) : (fs_new & ~st_r.fs_st); // [R24]
        if (fs_start) begin
            st_nxt.start_pend = 1'b1;
        end
        st_nxt.cap = rise;
        st_nxt.drv = st_r.cap;
        // receive position counts bit clocks from the frame or half start
        if (rise) begin
            st_nxt.start_pend = 1'b0;
            st_nxt.rx_phase   = fs_new;
            if (st_r.start_pend || fs_start) begin
                st_nxt.rx_idx = '0; // [R2]
            end else if (st_r.rx_idx != slot_map_pkg::FRAME_MAX) begin
                st_nxt.rx_idx = st_r.rx_idx + 13'h0001; // [R1]
            end
        end
        if (st_r.cap) begin
            // transmit position runs one bit ahead and wraps at the frame length, or at the half length in equal-half mode
            wrap = ((st_r.rx_idx + 13'h0001) >= lim);
            st_nxt.tx_pos   = wrap ? '0 : (st_r.rx_idx + 13'h0001); // [R2] [R23]
            st_nxt.tx_phase = wrap ? ~st_r.rx_phase : st_r.rx_phase;
            st_nxt.load     = wrap && (!equal_half_frame_mode || !st_r.rx_phase);
            // receive capture; both receive groups may read the same bits
            for (int c = 0; c < 2; c++) begin
                if (in_slot[2+c]) begin // [R7]
                    wb = width_bits(cfg_w[2+c]);
                    w  = (rel[2+c] == 5'h00) ? '0 : st_r.rx_word[c];
                    w[5'd31 - rel[2+c]] = st_r.din_st; // [R25]
                    st_nxt.rx_word[c] = w;
                    if (last[2+c]) begin
                        isnull = 1'b0;
                        audio  = w & top_mask(wb);
                        if (rx_isoc_enable && rx_null_scheme_select) begin
                            isnull = (audio == slot_map_pkg::NFS_WORD); // [R11] [R15]
                        end else if (rx_isoc_enable) begin
                            fb     = 8'(w >> (slot_map_pkg::WORD_BITS - wb));
                            isnull = !fb[rx_null_flag_position]; // [R14] [R16]
                            audio  = w & top_mask(wb - slot_map_pkg::BYTE_BITS); // [R16]
                        end
                        rx_drop[c] = isnull;
                        if (!isnull) begin
                            st_nxt.rx_sample[c] = audio[31:8]; // [R4]
                            st_nxt.rx_valid[c]  = 1'b1;
                            if (c == 0) begin
                                st_nxt.spdif_word  = audio; // [R5]
                                st_nxt.spdif_valid = !rx_isoc_enable; // [R10]
                            end
                        end
                    end
                end
            end
        end
        // per-frame sample or null decision; one decision serves both transmit channels
        if (st_nxt.load) begin
            if (!tx_isoc_enable) begin
                st_nxt.err = '0; // [R18]
            end else if ($signed(st_r.err) < $signed(fu)) begin
                st_nxt.err = st_r.err + su - fu; // [R20] [R22]
            end else begin
                send       = 1'b0; // [R8] [R9] [R21]
                st_nxt.err = st_r.err - fu; // [R20]
            end
            st_nxt.tx_null = !send;
            st_nxt.take    = send;
            for (int c = 0; c < 2; c++) begin
                wb = width_bits(cfg_w[c]);
                w  = {(c == 0) ? tx_chan1_sample : tx_chan2_sample, 8'h00}; // [R4]
                if (!send) begin
                    w = slot_map_pkg::NFS_WORD; // [R12] [R13]
                end else if (tx_isoc_enable && tx_null_scheme_select) begin
                    if ((w & top_mask(wb)) == slot_map_pkg::NFS_WORD) begin
                        w = w + (32'h0000_0001 << (slot_map_pkg::WORD_BITS - wb)); // [R12]
                    end
                end else if (tx_isoc_enable) begin
                    fb = slot_map_pkg::FLAG_ONE << tx_null_flag_position; // [R11] [R14]
                    w  = (w & top_mask(wb - slot_map_pkg::BYTE_BITS))
                         | ({24'h00_0000, fb} << (slot_map_pkg::WORD_BITS - wb)); // [R13]
                end
                st_nxt.tx_word[c] = w;
            end
        end
        // transmit bit, most significant first, driven only inside a slot
        if (st_r.drv) begin
            st_nxt.sdout    = 1'b0;
            st_nxt.sdout_oe = 1'b0;
            for (int c = 0; c < 2; c++) begin
                if (in_slot[c]) begin
                    st_nxt.sdout    = st_r.tx_word[c][5'd31 - rel[c]]; // [R25]
                    st_nxt.sdout_oe = 1'b1;
                end
            end
        end
        st_nxt.tx_rate = tx_isoc_enable ? tx_isoc_rate : slot_map_pkg::RATE_OFF; // [R17]
        st_nxt.rx_rate = rx_isoc_enable ? rx_isoc_rate : slot_map_pkg::RATE_OFF; // [R17]
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign serial_out             = st_r.sdout;
    assign serial_out_oe          = st_r.sdout_oe;
    assign tx_sample_take         = st_r.take;
    assign rx_group0_chan1_sample = st_r.rx_sample[0];
    assign rx_group0_chan1_valid  = st_r.rx_valid[0];
    assign rx_group1_chan1_sample = st_r.rx_sample[1];
    assign rx_group1_chan1_valid  = st_r.rx_valid[1];
    assign spdif_word             = st_r.spdif_word;
    assign spdif_valid            = st_r.spdif_valid;
    assign tx_conv_rate           = st_r.tx_rate;
    assign rx_conv_rate           = st_r.rx_rate;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_FIRST_BIT: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
        (st_r.drv && in_slot[0] && st_r.tx_pos == cfg_off[0])
        |=> (serial_out == $past(st_r.tx_word[0][31])) && serial_out_oe)
        else $error("first slot bit is not the word msb");
    AST_WIDTH: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
        in_slot[0] |-> ({1'b0, rel[0]} < width_bits(cfg_w[0])))
        else $error("transmit slot runs past its width");
    AST_CONV24: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
        (spdif_valid && rx_group0_chan1_valid) |-> (rx_group0_chan1_sample == spdif_word[31:8]))
        else $error("converter sample is not the top 24 bits");
    AST_SPDIF_NATIVE: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
        ($past(rx_isoc_enable) && rx_isoc_enable) |-> !spdif_valid)
        else $error("spdif fed while isochronous");
    AST_NFS_BUMP: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
        (st_r.load && tx_isoc_enable && tx_null_scheme_select && !st_r.tx_null)
        |-> ((st_r.tx_word[0] & top_mask(width_bits(cfg_w[0]))) != slot_map_pkg::NFS_WORD))
        else $error("valid sample leaves as a null code");
    AST_NULL_WORD: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
        (st_r.load && st_r.tx_null) |-> (st_r.tx_word[1] == slot_map_pkg::NFS_WORD) && !tx_sample_take)
        else $error("inserted null is not full scale");
    AST_ERR_RANGE: assert property (@(posedge sys_clk) disable iff (reset) // [R20]
        ($past(tx_isoc_enable) && tx_isoc_enable && $stable(tx_stream_rate) && $stable(tx_isoc_rate)
         && $past(st_r.load)) |-> (!st_r.err[8] && st_r.err < stream_units(tx_stream_rate)))
        else $error("null accumulator out of range");
    AST_NATIVE_TAKE: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
        (st_nxt.load && !tx_isoc_enable) |=> tx_sample_take ##1 !tx_sample_take)
        else $error("native frame did not take a sample");
    AST_RX_DROP: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
        (st_r.cap && last[2] && rx_drop[0]) |=> !rx_group0_chan1_valid)
        else $error("null sample delivered");
    AST_NSB_STRIP: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
        (st_r.cap && last[2] && !rx_drop[0] && rx_isoc_enable && !rx_null_scheme_select
         && cfg_w[2] == 2'h2) |=> (rx_group0_chan1_valid && rx_group0_chan1_sample[7:0] == 8'h00))
        else $error("indicator byte not stripped");
    AST_POS_LIMIT: assert property (@(posedge sys_clk) disable iff (reset) // [R24]
        (st_r.drv && lim >= slot_map_pkg::FRAME_MIN) |-> (st_r.tx_pos < lim))
        else $error("transmit position past frame or half");
endmodule

// >>> hdl/slot_if.sv
// channel slot configuration and position bundle
`timescale 1ns/100ps
interface slot_if;
    logic [12:0] offset;
    logic [1:0]  width_code;
    logic        active_phase;
    logic        half_mode;
    logic [12:0] limit;
    logic [12:0] pos;
    logic        phase;
    logic        in_slot;
    logic [4:0]  rel;
    logic        last;

    modport mgr (output offset, width_code, active_phase, half_mode, limit, pos, phase,
                 input  in_slot, rel, last);
    modport win (input  offset, width_code, active_phase, half_mode, limit, pos, phase,
                 output in_slot, rel, last);
endinterface

// >>> hdl/slot_map_pkg.sv
// shared constants for the serial port slot mapper
package slot_map_pkg;

    // ------------------------------------------------------------
    // frame and word geometry
    // ------------------------------------------------------------
    localparam int unsigned POS_W     = 13;
    localparam int unsigned OFFSET_W  = 12;
    localparam logic [12:0] FRAME_MIN = 13'h0010;
    localparam logic [12:0] FRAME_MAX = 13'h1000;
    localparam logic [5:0]  WORD_BITS = 6'h20;
    localparam logic [5:0]  BYTE_BITS = 6'h08;
    localparam logic [31:0] ALL_ONES  = 32'hffff_ffff;
    localparam logic [31:0] NFS_WORD  = 32'h8000_0000;
    localparam logic [7:0]  FLAG_ONE  = 8'h01;

    // ------------------------------------------------------------
    // isochronous rates, periods in units of 1/384 kHz
    // ------------------------------------------------------------
    localparam logic [1:0] RATE_48K  = 2'h0;
    localparam logic [1:0] RATE_96K  = 2'h1;
    localparam logic [1:0] RATE_192K = 2'h2;
    localparam logic [1:0] RATE_OFF  = 2'h3;
    localparam int unsigned ERR_W    = 9;
    localparam logic [8:0] UNITS_8K   = 9'h030;
    localparam logic [8:0] UNITS_12K  = 9'h020;
    localparam logic [8:0] UNITS_16K  = 9'h018;
    localparam logic [8:0] UNITS_24K  = 9'h010;
    localparam logic [8:0] UNITS_32K  = 9'h00c;
    localparam logic [8:0] UNITS_48K  = 9'h008;
    localparam logic [8:0] UNITS_96K  = 9'h004;
    localparam logic [8:0] UNITS_192K = 9'h002;

endpackage

// >>> hdl/slot_window.sv
// decides whether a bit position falls inside one channel's slot
`timescale 1ns/100ps
module slot_window (
    slot_if.win s
);
    logic [13:0] diff;
    logic [5:0]  wbits;

    always_comb begin
        diff      = {1'b0, s.pos} - {1'b0, s.offset};
        wbits     = {1'b0, s.width_code, 3'b000} + slot_map_pkg::BYTE_BITS;
        s.in_slot = (s.pos >= s.offset) && (diff < {8'h00, wbits}) && (s.pos < s.limit)
                    && (!s.half_mode || (s.phase == s.active_phase));
        s.rel     = diff[4:0];
        s.last    = s.in_slot && ({1'b0, s.rel} == (wbits - 6'h01));
    end
endmodule

// >>> verification/host_model.sv
// host side model: masters bit clock and frame sync, 32-bit frames
`timescale 1ns/100ps
module host_model (
    input  wire logic        run,
    input  wire logic [31:0] tx_frame,
    input  wire logic        serial_out,
    output logic             bit_clk,
    output logic             frame_sync,
    output logic             serial_in,
    output logic [31:0]      rx_frame,
    output int               frames
);
    logic [31:0] cap;
    initial begin
        {bit_clk, frame_sync, serial_in, frames, rx_frame, cap} = '0;
        wait (run);
        forever begin
            for (int k = 0; k < 32; k++) begin // frame length matches the setting
                frame_sync = (k == 0); // sync edge leads bit zero
                serial_in = tx_frame[31 - k];
                #100 bit_clk = 1'b1;
                cap[31 - k] = serial_out;
                #100 bit_clk = 1'b0;
            end
            rx_frame = cap;
            frames++;
        end
    end
endmodule

// >>> verification/testbench.sv
// self-checking bench for the slot mapper
`timescale 1ns/100ps
module testbench;
    logic sys_clk, reset, run, ph, serial_out, serial_out_oe, bit_clk, frame_sync, serial_in;
    logic tx_sample_take, rx_group0_chan1_valid, rx_group1_chan1_valid, spdif_valid;
    logic tx_isoc_enable, rx_isoc_enable, tx_null_scheme_select, rx_null_scheme_select;
    logic [1:0] rate, tx_conv_rate, rx_conv_rate, wid [4];
    logic [2:0] tx_stream_rate, flag;
    logic [7:0] off [4];
    logic [23:0] s1, s2, rx_group0_chan1_sample, rx_group1_chan1_sample, last;
    logic [31:0] tx_frame, rx_frame, spdif_word;
    int frames, n_val, n_v1, n_take, n_sp, fails, checks_done;
    int exp_take [6] = '{2, 3, 4, 6, 8, 12};

    serial_port_slot_mapper_isoc i_dut (.sys_clk, .reset, .bit_clk, .frame_sync, .serial_in,
        .serial_out, .serial_out_oe, .frame_length_low(13'h0020), .equal_half_frame_mode(ph),
        .tx_chan1_offset_high(4'h0), .tx_chan1_offset_low(off[0]), .tx_chan1_width(wid[0]),
        .tx_chan1_phase(ph), .tx_chan2_offset_high(4'h0), .tx_chan2_offset_low(off[1]),
        .tx_chan2_width(wid[1]), .tx_chan2_phase(ph), .rx_group0_chan1_offset_high(4'h0),
        .rx_group0_chan1_offset_low(off[2]), .rx_group0_chan1_width(wid[2]),
        .rx_group0_chan1_phase(ph), .rx_group1_chan1_offset_high(4'h0),
        .rx_group1_chan1_offset_low(off[3]), .rx_group1_chan1_width(wid[3]),
        .rx_group1_chan1_phase(ph), .tx_isoc_enable, .rx_isoc_enable, .tx_null_scheme_select,
        .rx_null_scheme_select, .tx_null_flag_position(flag), .rx_null_flag_position(flag),
        .tx_isoc_rate(rate), .rx_isoc_rate(rate), .tx_stream_rate, .tx_chan1_sample(s1),
        .tx_chan2_sample(s2), .tx_sample_take, .rx_group0_chan1_sample, .rx_group0_chan1_valid,
        .rx_group1_chan1_sample, .rx_group1_chan1_valid, .spdif_word, .spdif_valid,
        .tx_conv_rate, .rx_conv_rate);
    host_model i_host (.run, .tx_frame, .serial_out, .bit_clk, .frame_sync, .serial_in,
        .rx_frame, .frames);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_take += tx_sample_take;
        n_sp += spdif_valid;
        n_v1 += (rx_group1_chan1_valid === 1'b1);
        if (rx_group0_chan1_valid === 1'b1) begin
            n_val++;
            last = rx_group0_chan1_sample;
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // frame waits, bounded; measure settles one frame then counts
    // ------------------------------------------------------------
    task automatic frames_wait(int n);
        int goal;
        goal = frames + n;
        for (int i = 0; i < n * 400 && frames < goal; i++) @(negedge sys_clk);
        if (frames < goal) begin
            fails++;
            print_verdict();
        end
    endtask
    task automatic measure(int n);
        frames_wait(1);
        {n_val, n_take, n_sp, n_v1} = '0;
        frames_wait(n);
    endtask

    initial begin
        {reset, run, ph, tx_isoc_enable, rx_isoc_enable, fails, checks_done} = '0;
        {tx_null_scheme_select, rx_null_scheme_select, rate, flag, tx_stream_rate} = '0;
        {n_val, n_take, n_sp, last} = '0;
        off = '{8'h00, 8'h18, 8'h00, 8'h08}; // rx groups share bits
        wid = '{2'h2, 2'h0, 2'h2, 2'h1};
        s1 = 24'h123456;
        s2 = 24'hc30000;
        tx_frame = 32'ha5c30f96;
        reset = 1'b1;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        run = 1'b1;
        measure(3);
        check("tx chan1", rx_frame[31:8], 24'h123456);
        check("tx chan2", rx_frame[7:0], 8'hc3);
        check("rx group0", rx_group0_chan1_sample, 24'ha5c30f);
        check("rx group1", rx_group1_chan1_sample, 24'hc30f00);
        check("spdif", spdif_word[31:8], 24'ha5c30f);
        check("conv off", {tx_conv_rate, rx_conv_rate}, 4'hf);
        check("rx count", n_val, 3);
        check("rx1 count", n_v1, 3);
        {tx_isoc_enable, rx_isoc_enable, rx_null_scheme_select, rate} = 5'h1d; // whole port
        tx_frame = 32'h800000ff;
        measure(3);
        check("nfs drop", n_val, 0);
        check("spdif isoc", n_sp, 0);
        check("conv on", rx_conv_rate, 2'h1);
        {rx_null_scheme_select, flag} = 4'h3;
        tx_frame = 32'h12340800; // every frame valid keeps ideal spacing
        measure(3);
        check("flag keep", n_val, 3);
        check("flag strip", last, 24'h123400);
        tx_frame = 32'h1234f700;
        measure(3);
        check("flag null", n_val, 0);
        rx_isoc_enable = 1'b0;
        rate = 2'h0;
        for (int r = 0; r < 6; r++) begin
            tx_isoc_enable = 1'b0;
            tx_stream_rate = 3'(r);
            frames_wait(1);
            tx_isoc_enable = 1'b1;
            measure(12);
            check("take count", n_take, exp_take[r]);
        end
        check("tx flag", rx_frame, 32'h12340808);
        check("tx conv", tx_conv_rate, 2'h0);
        tx_null_scheme_select = 1'b1;
        s1 = 24'h800000;
        measure(2);
        check("nfs bump", rx_frame[31:8], 24'h800001);
        print_verdict();
    end
endmodule
